// ---- design/lvat_pkg.sv ----
// constants and types for the line voltage and ac termination registers
package lvat_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LINE_VOLT = 8'h1d;
   localparam logic [7:0] IDX_AC_TERM = 8'h1e;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
   localparam logic [7:0] IDX_LV_CTRL = 8'h42;
   localparam int unsigned ADDR_W = 12;
   // ac termination control fields
   localparam int unsigned AC_SEL_LSB = 0;
   localparam int unsigned AC_SEL_MSB = 3;
   localparam int unsigned DOUBLE_FULL_SCALE_EN_BIT = 4;
   localparam int unsigned AC_RSVD_BIT = 5;
   localparam logic [5:0] AC_TERM_RESET = 6'h00;
   localparam logic [3:0] AC_TERM_600 = 4'h0;
   localparam logic [3:0] AC_TERM_900 = 4'h1;
   localparam logic [3:0] AC_TERM_REVC_ONLY = 4'ha;
   localparam logic [3:0] AC_TERM_GLOBAL = 4'hf;
   // line-side revision code from which the 2x mode works
   localparam logic [3:0] REV_DOUBLE_FULL_SCALE_EN_MIN = 4'h5;
   // line voltage control register
   localparam int unsigned LV_FORCE_BIT = 0;
   localparam logic LV_FORCE_RESET = 1'b0;
   // loop voltage: 1 V per lsb, clamp at or below 3 V in magnitude
   localparam int LV_CLAMP_VOLTS = 3;
   localparam logic signed [7:0] LV_CLAMP_CODE = 8'sh03;
   localparam logic [7:0] LV_ZERO = 8'h00;
   // interrupt events
   localparam int unsigned NUM_EV = 2;
   localparam int unsigned EV_POL_BIT = 0;
   localparam int unsigned EV_LINE_BIT = 1;
   localparam logic [1:0] EV_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_LINE_VOLT,
      SEL_AC_TERM,
      SEL_IRQ_STAT,
      SEL_IRQ_MASK,
      SEL_LV_CTRL
   } lvat_sel_t;

   // byte address to register; low two bits must be zero
   function automatic lvat_sel_t lvat_decode(input logic [ADDR_W-1:0] a);
      lvat_sel_t s;
      s = SEL_NONE;
      if (a[1:0] == 2'h0)
      begin
         case (a[ADDR_W-1:2])
            {2'h0, IDX_LINE_VOLT}: s = SEL_LINE_VOLT;
            {2'h0, IDX_AC_TERM}: s = SEL_AC_TERM;
            {2'h0, IDX_IRQ_STAT}: s = SEL_IRQ_STAT;
            {2'h0, IDX_IRQ_MASK}: s = SEL_IRQ_MASK;
            {2'h0, IDX_LV_CTRL}: s = SEL_LV_CTRL;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction
endpackage

// ---- design/lvat_volt_cond.sv ----
// loop voltage conditioning and polarity reversal detection
`timescale 1ns/100ps
module lvat_volt_cond
   import lvat_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] loop_volt_meas,
   input wire logic line_present,
   input wire logic line_voltage_force_disable,
   output logic [7:0] loop_voltage_value,
   output logic pol_rev_pulse,
   output logic line_chg_pulse
);
   logic [7:0] value_r, value_nxt;
   logic pol_r, pol_nxt, line_r, line_nxt, chg_r, chg_nxt;
   logic small_v;

   always_comb
   begin
      small_v = ($signed(loop_volt_meas) <= LV_CLAMP_CODE) &&
                ($signed(loop_volt_meas) >= -LV_CLAMP_CODE);
      // tracked every cycle, hook state ignored
      value_nxt = loop_volt_meas;
      if (small_v && !line_voltage_force_disable)
         value_nxt = LV_ZERO;
      if (!line_present)
         value_nxt = LV_ZERO;
      pol_nxt = value_nxt[7] ^ value_r[7];
      line_nxt = line_present;
      chg_nxt = line_present ^ line_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         value_r <= LV_ZERO;
         pol_r <= 1'b0;
         line_r <= 1'b0;
         chg_r <= 1'b0;
      end
      else
      begin
         value_r <= value_nxt;
         pol_r <= pol_nxt;
         line_r <= line_nxt;
         chg_r <= chg_nxt;
      end
   end

   assign loop_voltage_value = value_r;
   assign pol_rev_pulse = pol_r;
   assign line_chg_pulse = chg_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   no_line_zero_a: assert property (!line_present |=> value_r == 8'h00)
      else $error("value not zero without line");
   clamp_small_a: assert property (
      (line_present && !line_voltage_force_disable &&
       $signed(loop_volt_meas) < 4 && $signed(loop_volt_meas) > -4)
      |=> value_r == 8'h00)
      else $error("small voltage not clamped");
   value_track_a: assert property (
      (line_present && $signed(loop_volt_meas) > 3)
      |=> value_r == $past(loop_volt_meas))
      else $error("loop voltage not tracked");
   pol_pulse_a: assert property (
      ($past(value_r[7]) != value_r[7]) |-> pol_r)
      else $error("polarity change missed");
   pol_rev_c: cover property (line_present ##1 pol_r);
endmodule // lvat_volt_cond

// ---- design/lvat_irq.sv ----
// sticky event flags, mask and interrupt level
`timescale 1ns/100ps
module lvat_irq
   import lvat_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NUM_EV-1:0] ev_set,
   input wire logic [NUM_EV-1:0] ev_clr,
   input wire logic [NUM_EV-1:0] ev_mask,
   output logic [NUM_EV-1:0] ev_status,
   output logic irq
);
   logic [NUM_EV-1:0] stat_r, stat_nxt;
   logic irq_r, irq_nxt;

   // set beats a clear in the same cycle so no event is lost
   for (genvar i = 0; i < NUM_EV; i++)
   begin : g_sticky
      always_comb
      begin
         stat_nxt[i] = ev_set[i] | (stat_r[i] & ~ev_clr[i]);
      end
   end

   always_comb
   begin
      irq_nxt = |(stat_r & ev_mask);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stat_r <= EV_RESET;
         irq_r <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign ev_status = stat_r;
   assign irq = irq_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   set_wins_a: assert property (ev_set[EV_POL_BIT] |=> stat_r[EV_POL_BIT])
      else $error("event lost against clear");
   irq_level_a: assert property (irq_r == |$past(stat_r & ev_mask))
      else $error("irq level mismatch");
   irq_raise_c: cover property (ev_set != 0 ##1 ev_mask != 0 ##1 irq_r);
endmodule // lvat_irq

// ---- design/lvat_regs.sv ----
// axi4-lite register bank for loop voltage status and ac termination
//
// Function
// - loop voltage read back as eight bits, one volt per lsb
// - value refreshed continuously, on-hook or off-hook alike
// - value is two's complement, msb is the sign
// - bit 7 follows tip/ring polarity; its toggle marks a reversal
// - no line connected reads as all zeros
// - termination bit 5 accepts zero or one with no effect
// - termination bit 4 selects double full scale, clear gives default
// - double full scale acts only with line-side revision e or later
// - bits 3:0 pick one of sixteen ac terminations
// - voltage at or below three volts in magnitude, either polarity, reads zero unless force-disabled
`timescale 1ns/100ps
module lvat_regs
   import lvat_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] loop_volt_meas,
   input wire logic line_present,
   input wire logic [3:0] line_side_rev,
   output logic [3:0] ac_term_select,
   output logic double_full_scale_en,
   output logic irq
);
   // write channel state
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic aw_have_r, aw_have_nxt;
   logic w_have_r, w_have_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic w_lane0_r, w_lane0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   // read channel state
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   // register state
   logic [5:0] ac_term_r, ac_term_nxt;
   logic lv_force_r, lv_force_nxt;
   logic [NUM_EV-1:0] mask_r, mask_nxt;
   logic [3:0] term_sel_r, term_sel_nxt;
   logic double_full_scale_en_r, double_full_scale_en_nxt;
   // internal
   logic do_write;
   lvat_sel_t wsel, rsel;
   logic [NUM_EV-1:0] ev_clr, ev_set, ev_status;
   logic [7:0] loop_voltage_value;
   logic pol_rev_pulse, line_chg_pulse;

   lvat_volt_cond u_volt (
      .aclk(aclk),
      .aresetn(aresetn),
      .loop_volt_meas(loop_volt_meas),
      .line_present(line_present),
      .line_voltage_force_disable(lv_force_r),
      .loop_voltage_value(loop_voltage_value),
      .pol_rev_pulse(pol_rev_pulse),
      .line_chg_pulse(line_chg_pulse)
   );

   // reversal raised to software as an event
   always_comb
   begin
      ev_set = '0;
      ev_set[EV_POL_BIT] = pol_rev_pulse;
      ev_set[EV_LINE_BIT] = line_chg_pulse;
   end

   lvat_irq u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .ev_set(ev_set),
      .ev_clr(ev_clr),
      .ev_mask(mask_r),
      .ev_status(ev_status),
      .irq(irq)
   );

   // address and data may arrive in either order; one write at a time
   always_comb
   begin
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_lane0_nxt = w_lane0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      wsel = lvat_decode(aw_addr_r);
      do_write = aw_have_r && w_have_r && !bvalid_r;
      if (awready_r && s_axi_awvalid)
      begin
         awready_nxt = 1'b0;
         aw_have_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (wready_r && s_axi_wvalid)
      begin
         wready_nxt = 1'b0;
         w_have_nxt = 1'b1;
         w_data_nxt = s_axi_wdata[7:0];
         w_lane0_nxt = s_axi_wstrb[0];
      end
      if (do_write)
      begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_r && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_lane0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_lane0_r <= w_lane0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // register updates; only byte lane 0 carries data
   always_comb
   begin
      ac_term_nxt = ac_term_r;
      lv_force_nxt = lv_force_r;
      mask_nxt = mask_r;
      ev_clr = '0;
      if (do_write && w_lane0_r)
      begin
         case (wsel)
            // bit 5 kept, bits 7:6 dropped
            SEL_AC_TERM: ac_term_nxt = w_data_r[5:0];
            SEL_LV_CTRL: lv_force_nxt = w_data_r[LV_FORCE_BIT];
            SEL_IRQ_MASK: mask_nxt = w_data_r[NUM_EV-1:0];
            SEL_IRQ_STAT: ev_clr = w_data_r[NUM_EV-1:0];
            default: ev_clr = '0;
         endcase
      end
      // low nibble drives the termination select
      term_sel_nxt = ac_term_r[AC_SEL_MSB:AC_SEL_LSB];
      // 2x mode gated by line-side revision
      double_full_scale_en_nxt = ac_term_r[DOUBLE_FULL_SCALE_EN_BIT] && (line_side_rev >= REV_DOUBLE_FULL_SCALE_EN_MIN);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ac_term_r <= AC_TERM_RESET;
         lv_force_r <= LV_FORCE_RESET;
         mask_r <= EV_RESET;
         term_sel_r <= AC_TERM_600;
         double_full_scale_en_r <= 1'b0;
      end
      else
      begin
         ac_term_r <= ac_term_nxt;
         lv_force_r <= lv_force_nxt;
         mask_r <= mask_nxt;
         term_sel_r <= term_sel_nxt;
         double_full_scale_en_r <= double_full_scale_en_nxt;
      end
   end

   // read path answers one cycle after the address is taken
   always_comb
   begin
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rsel = lvat_decode(s_axi_araddr);
      if (arready_r && s_axi_arvalid)
      begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case (rsel)
            SEL_LINE_VOLT: rdata_nxt = loop_voltage_value;
            SEL_AC_TERM: rdata_nxt = {2'h0, ac_term_r};
            SEL_IRQ_STAT: rdata_nxt = {6'h00, ev_status};
            SEL_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
            SEL_LV_CTRL: rdata_nxt = {7'h00, lv_force_r};
            default:
            begin
               rdata_nxt = 8'h00;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_r && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = {24'h00_0000, rdata_r};
   assign s_axi_rresp = rresp_r;
   assign ac_term_select = term_sel_r;
   assign double_full_scale_en = double_full_scale_en_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   double_full_scale_en_gate_a: assert property (
      double_full_scale_en ==
      $past(ac_term_r[4] && line_side_rev >= 4'h5))
      else $error("double full scale not gated by revision");
   term_follow_a: assert property (
      (do_write && w_lane0_r && wsel == SEL_AC_TERM)
      ##2 1'b1 |-> ac_term_select == $past(w_data_r[3:0], 2))
      else $error("termination select not applied");
   ac_read_a: assert property (
      (arready_r && s_axi_arvalid && rsel == SEL_AC_TERM)
      |=> rvalid_r && rdata_r[7:6] == 2'h0
      && rdata_r[5:0] == $past(ac_term_r))
      else $error("ac termination readback wrong");
   rsvd_no_effect_a: assert property (
      $changed(ac_term_r[5]) && $stable(ac_term_r[4:0]) &&
      $stable(line_side_rev)
      |=> $stable(term_sel_r) && $stable(double_full_scale_en_r))
      else $error("reserved bit changed behaviour");
   write_resp_a: assert property (do_write |=> bvalid_r)
      else $error("write response late");
   ac_write_c: cover property (do_write && wsel == SEL_AC_TERM);
   volt_read_c: cover property (
      arready_r && s_axi_arvalid && rsel == SEL_LINE_VOLT);
endmodule // lvat_regs

// ---- verification/lvat_tb.sv ----
// self-checking bench for the loop voltage and ac termination registers
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb
   import lvat_pkg::*;
   ;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [7:0] loop_volt_meas = '0;
   logic line_present = 1'b0;
   logic [3:0] line_side_rev = '0;
   logic [3:0] ac_term_select;
   logic double_full_scale_en;
   logic irq;
   int fails = 0;
   int samples_checked = 0;
   logic [7:0] mv [8] = '{8'h30, 8'hd0, 8'h03, 8'hfd, 8'h04, 8'hfc,
      8'h03, 8'hfd};
   logic fd [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
   logic [7:0] ev [8] = '{8'h30, 8'hd0, 8'h00, 8'h00, 8'h04, 8'hfc,
      8'h03, 8'hfd};

   always #50 aclk = ~aclk;

   lvat_regs dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .loop_volt_meas(loop_volt_meas), .line_present(line_present),
      .line_side_rev(line_side_rev), .ac_term_select(ac_term_select),
      .double_full_scale_en(double_full_scale_en), .irq(irq)
   );

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic hang(input string nm);
      fails++;
      $display("ERROR %s expected handshake seen timeout", nm);
      stop_test();
   endtask

   // one write; address and data offered together, released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] st, input logic [1:0] er);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (40)
      begin
         @(posedge aclk);
         if (s_axi_bvalid && aw_ok && w_ok)
         begin
            `CHK("bresp", er, s_axi_bresp)
            s_axi_bready <= 1'b0;
            return;
         end
         if (!aw_ok && s_axi_awready)
         begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready)
         begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      hang("write");
   endtask

   // one read compared against the expected word and response
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
      input logic [1:0] er, input string nm);
      bit ar_ok;
      ar_ok = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (40)
      begin
         @(posedge aclk);
         if (s_axi_rvalid && ar_ok)
         begin
            `CHK(nm, ed, s_axi_rdata)
            `CHK("rresp", er, s_axi_rresp)
            s_axi_rready <= 1'b0;
            return;
         end
         if (!ar_ok && s_axi_arready)
         begin
            ar_ok = 1;
            s_axi_arvalid <= 1'b0;
         end
      end
      hang("read");
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   initial
   begin
      logic [31:0] d;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("term_sel_rst", 4'h0, ac_term_select)
      `CHK("irq_rst", 1'b0, irq)
      rd(ba(IDX_AC_TERM), 32'h0, RESP_OKAY, "term_rst");
      rd(ba(IDX_LINE_VOLT), 32'h0, RESP_OKAY, "no_line");
      // every code, bit 5 toggled, bits 7:6 written high
      for (int i = 0; i < 16; i++)
      begin
         line_side_rev <= i[0] ? REV_DOUBLE_FULL_SCALE_EN_MIN :
            (i[3:0] == AC_TERM_REVC_ONLY) ? REV_DOUBLE_FULL_SCALE_EN_MIN - 4'h2 :
            REV_DOUBLE_FULL_SCALE_EN_MIN - 4'h1;
         d = 32'hffff_ffd0 | i;
         d[5] = i[1];
         wr(ba(IDX_AC_TERM), d, 4'hf, RESP_OKAY);
         settle(2);
         `CHK("term_sel", i[3:0], ac_term_select)
         // voltage adjust lives outside this bank
         `CHK("double_full_scale_en", i[0], double_full_scale_en)
         rd(ba(IDX_AC_TERM), {26'h0, i[1], 1'b1, i[3:0]}, RESP_OKAY,
            "term_rd");
      end
      wr(ba(IDX_AC_TERM), 32'h0000_0000, 4'h1, RESP_OKAY);
      settle(2);
      `CHK("double_full_scale_en_off", 1'b0, double_full_scale_en)
      `CHK("term_600", AC_TERM_600, ac_term_select)
      wr(ba(IDX_AC_TERM), 32'h0000_001f, 4'h0, RESP_OKAY);
      rd(ba(IDX_AC_TERM), 32'h0, RESP_OKAY, "strb_off");
      // reserved bit alone leaves the outputs alone
      wr(ba(IDX_AC_TERM), 32'h0000_0020, 4'h1, RESP_OKAY);
      settle(2);
      `CHK("rsvd_sel", AC_TERM_600, ac_term_select)
      `CHK("rsvd_double_full_scale_en", 1'b0, double_full_scale_en)
      rd(ba(IDX_AC_TERM), 32'h0000_0020, RESP_OKAY, "rsvd_rd");
      // loop voltage table, clamp and its disable
      line_present <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         wr(ba(IDX_LV_CTRL), {31'h0, fd[i]}, 4'h1, RESP_OKAY);
         loop_volt_meas <= mv[i];
         settle(3);
         rd(ba(IDX_LINE_VOLT), {24'h0, ev[i]}, RESP_OKAY,
            "loop_v");
      end
      wr(ba(IDX_LINE_VOLT), 32'h0000_0055, 4'h1, RESP_OKAY);
      rd(ba(IDX_LINE_VOLT), 32'h0000_00fd, RESP_OKAY, "ro_volt");
      line_present <= 1'b0;
      settle(3);
      rd(ba(IDX_LINE_VOLT), 32'h0, RESP_OKAY, "unplug");
      // polarity reversal event, masked and unmasked
      wr(ba(IDX_LV_CTRL), 32'h0, 4'h1, RESP_OKAY);
      wr(ba(IDX_IRQ_MASK), 32'h1, 4'h1, RESP_OKAY);
      line_present <= 1'b1;
      loop_volt_meas <= 8'h20;
      settle(6);
      wr(ba(IDX_IRQ_STAT), 32'h3, 4'h1, RESP_OKAY);
      settle(3);
      `CHK("irq_idle", 1'b0, irq)
      loop_volt_meas <= 8'he0;
      settle(6);
      `CHK("irq_pol", 1'b1, irq)
      rd(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY, "stat_pol");
      wr(ba(IDX_IRQ_STAT), 32'h1, 4'h1, RESP_OKAY);
      settle(3);
      `CHK("irq_clr", 1'b0, irq)
      rd(ba(IDX_IRQ_STAT), 32'h0, RESP_OKAY, "stat_clr");
      wr(ba(IDX_IRQ_MASK), 32'h0, 4'h1, RESP_OKAY);
      loop_volt_meas <= 8'h20;
      settle(6);
      `CHK("irq_mask", 1'b0, irq)
      rd(ba(IDX_IRQ_STAT), 32'h1, RESP_OKAY, "stat_back");
      // unmapped and misaligned places
      rd(12'h07c, 32'h0, RESP_SLVERR, "unmapped");
      rd(12'h075, 32'h0, RESP_SLVERR, "misalign");
      wr(12'h07c, 32'h0000_00ff, 4'h1, RESP_SLVERR);
      stop_test();
   end
endmodule // tb
